//--- pkg/vector_resolver_consts.vh
// Offsets, field positions, vector numbers and reset values of the resolver
`ifndef VECTOR_RESOLVER_CONSTS_VH
`define VECTOR_RESOLVER_CONSTS_VH

// AXI4-Lite register byte offsets
`define OFS_PRIO_A      8'h00
`define OFS_PRIO_B      8'h04
`define OFS_MODE        8'h08
`define OFS_VECTOR      8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_MASK    8'h14

// Reset values
`define PRIO_A_RESET    8'h00
`define PRIO_B_RESET    8'h00
`define MODE_RESET      1'b0

// Field positions in priority_config_reg_a
`define PA_EXT0         7
`define PA_EXT1         6
`define PA_EXT45        4
`define PA_WDT          3
`define PA_TMR0         2
`define PA_TMR1         1
`define PA_TMR2         0
// Field positions in priority_config_reg_b
`define PB_TMR3         7
`define PB_TMR4         6
`define PB_SER0         3
`define PB_SER1         2
`define PB_ADC          1
// Writable bits of the priority registers
`define PA_WMASK        8'hDF
`define PB_WMASK        8'hCE

// Vector numbers
`define VEC_NMI         6'h07
`define VEC_EXT0        6'h0C
`define VEC_EXT1        6'h0D
`define VEC_EXT4        6'h10
`define VEC_EXT5        6'h11
`define VEC_WDT         6'h14
`define VEC_TMR0        6'h18
`define VEC_TMR1        6'h1C
`define VEC_TMR2        6'h20
`define VEC_TMR3        6'h24
`define VEC_TMR4        6'h28
`define VEC_SER0        6'h34
`define VEC_SER1        6'h38
`define VEC_ADC         6'h3C

// Interrupt status bits
`define ST_NMI          0
`define ST_CHANGE       1

`endif

//--- rtl/interrupt_vector_priority_resolver.v
// Interrupt vector priority resolver with AXI4-Lite configuration registers
//
// Contract
// - Equal-level pending requests resolve to the lowest vector number.
// - NMI always wins, ignores group bits; other sources use priority regs.
// - Reset clears group bits so order is pure vector-number order.
// - Table address is vector times two normal, four advanced; 16 bits.
// - NMI uses vector 7, address 000E normal or 001C advanced.
// - External request 0 vector 12 bit A7; request 1 vector 13 bit A6.
// - External requests 4 and 5 use vectors 16, 17 sharing bit A4.
// - Watchdog interval overflow uses vector 20 and bit A3.
// - Timer 0 match A, match B, overflow use vectors 24-26, bit A2.
// - Timer 1 match A, match B, overflow use vectors 28-30, bit A1.
// - Timer 2 match A, match B, overflow use vectors 32-34, bit A0.
// - Timer 3 match A, match B, overflow use vectors 36-38, bit B7.
// - Timer 4 match A, match B, overflow use vectors 40-42, bit B6.
// - Serial 0 rx error, rx full, tx empty, tx end use vectors 52-55, B3.
// - Serial 1 rx error, rx full, tx empty, tx end use vectors 56-59, B2.
// - A/D conversion end uses vector 60, bit B1, lowest default.
// - Level-1 sources beat all level-0 sources; ties by vector order.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "vector_resolver_consts.vh"

module interrupt_vector_priority_resolver (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Interrupt sources, active high, held by the sources until serviced
   input  wire        nmi_request,
   input  wire        ext_request_0,
   input  wire        ext_request_1,
   input  wire        ext_request_4,
   input  wire        ext_request_5,
   input  wire        watchdog_interval_overflow,
   input  wire [2:0]  timer0_req,
   input  wire [2:0]  timer1_req,
   input  wire [2:0]  timer2_req,
   input  wire [2:0]  timer3_req,
   input  wire [2:0]  timer4_req,
   input  wire [3:0]  serial0_req,
   input  wire [3:0]  serial1_req,
   input  wire        adc_conversion_end,
   // Resolved request towards the core
   output reg         req_valid,
   output reg  [5:0]  req_vector,
   output reg  [15:0] req_address,
   output reg         req_level,
   // Interrupt to the system
   output wire        irq
);

   // ==========================================================
   // Functions
   // ==========================================================
   // Table entry address of a vector
   function [15:0] vec_addr;
      input [5:0] vec;
      input       adv;
      begin
         if (adv)
            vec_addr = {8'h00, vec, 2'b00};
         else
            vec_addr = {9'h000, vec, 1'b0};
      end
   endfunction

   // Lowest-numbered set bit of a 64-entry request map
   function [6:0] first_set;
      input [63:0] map;
      integer i;
      begin
         first_set = 7'h40;
         for (i = 63; i >= 0; i = i - 1) begin
            if (map[i])
               first_set = i[6:0];
         end
      end
   endfunction

   // ==========================================================
   // Registers
   // ==========================================================
   reg [7:0]  prio_a_reg;
   reg [7:0]  prio_b_reg;
   reg        adv_mode_reg;
   reg [1:0]  status_reg;
   reg [1:0]  mask_reg;
   reg        aw_held_reg;
   reg [7:0]  aw_addr_reg;
   reg        w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg [5:0]  last_vec_reg;
   reg        last_valid_reg;

   // ==========================================================
   // Request maps indexed by vector number
   // ==========================================================
   reg [63:0] pend_map;
   reg [63:0] group_hi;

   always @* begin
      pend_map = 64'h0000000000000000;
      group_hi = 64'h0000000000000000;
      pend_map[`VEC_EXT0]       = ext_request_0;
      pend_map[`VEC_EXT1]       = ext_request_1;
      pend_map[`VEC_EXT4]       = ext_request_4;
      pend_map[`VEC_EXT5]       = ext_request_5;
      pend_map[`VEC_WDT]        = watchdog_interval_overflow;
      pend_map[`VEC_TMR0 +: 3]  = timer0_req;
      pend_map[`VEC_TMR1 +: 3]  = timer1_req;
      pend_map[`VEC_TMR2 +: 3]  = timer2_req;
      pend_map[`VEC_TMR3 +: 3]  = timer3_req;
      pend_map[`VEC_TMR4 +: 3]  = timer4_req;
      pend_map[`VEC_SER0 +: 4]  = serial0_req;
      pend_map[`VEC_SER1 +: 4]  = serial1_req;
      pend_map[`VEC_ADC]        = adc_conversion_end;
      group_hi[`VEC_EXT0]       = prio_a_reg[`PA_EXT0];
      group_hi[`VEC_EXT1]       = prio_a_reg[`PA_EXT1];
      group_hi[`VEC_EXT4 +: 2]  = {2{prio_a_reg[`PA_EXT45]}};
      group_hi[`VEC_WDT]        = prio_a_reg[`PA_WDT];
      group_hi[`VEC_TMR0 +: 3]  = {3{prio_a_reg[`PA_TMR0]}};
      group_hi[`VEC_TMR1 +: 3]  = {3{prio_a_reg[`PA_TMR1]}};
      group_hi[`VEC_TMR2 +: 3]  = {3{prio_a_reg[`PA_TMR2]}};
      group_hi[`VEC_TMR3 +: 3]  = {3{prio_b_reg[`PB_TMR3]}};
      group_hi[`VEC_TMR4 +: 3]  = {3{prio_b_reg[`PB_TMR4]}};
      group_hi[`VEC_SER0 +: 4]  = {4{prio_b_reg[`PB_SER0]}};
      group_hi[`VEC_SER1 +: 4]  = {4{prio_b_reg[`PB_SER1]}};
      group_hi[`VEC_ADC]        = prio_b_reg[`PB_ADC];
   end

   // ==========================================================
   // Arbitration
   // ==========================================================
   // Reserved vectors never enter pend_map, so they can never win.
   wire [6:0] hi_win = first_set(pend_map & group_hi);
   wire [6:0] lo_win = first_set(pend_map & ~group_hi);

   reg        win_valid;
   reg [5:0]  win_vec;
   reg        win_level;

   always @* begin
      win_valid = 1'b1;
      win_level = 1'b1;
      win_vec   = `VEC_NMI;
      if (nmi_request) begin
         win_vec   = `VEC_NMI;
         win_level = 1'b1;
      end else if (!hi_win[6]) begin
         win_vec   = hi_win[5:0];
         win_level = 1'b1;
      end else if (!lo_win[6]) begin
         win_vec   = lo_win[5:0];
         win_level = 1'b0;
      end else begin
         win_valid = 1'b0;
         win_level = 1'b0;
      end
   end

   // Registered outputs; losers are not latched and stay visible
   // at the inputs, so they win as soon as the higher one drops.
   always @(posedge aclk) begin
      if (!aresetn) begin
         req_valid   <= 1'b0;
         req_vector  <= 6'h00;
         req_address <= 16'h0000;
         req_level   <= 1'b0;
      end else begin
         req_valid   <= win_valid;
         req_vector  <= win_valid ? win_vec : 6'h00;
         req_address <= win_valid ? vec_addr(win_vec, adv_mode_reg)
                                  : 16'h0000;
         req_level   <= win_level;
      end
   end

   // ==========================================================
   // Interrupt status: NMI seen, winning vector changed
   // ==========================================================
   wire [1:0] events;
   assign events[`ST_NMI]    = nmi_request & win_valid &
                               (win_vec != last_vec_reg);
   assign events[`ST_CHANGE] = win_valid &
                               (!last_valid_reg || win_vec != last_vec_reg);
   assign irq = |(status_reg & mask_reg);

   always @(posedge aclk) begin
      if (!aresetn) begin
         last_vec_reg   <= 6'h00;
         last_valid_reg <= 1'b0;
      end else begin
         last_vec_reg   <= win_valid ? win_vec : 6'h00;
         last_valid_reg <= win_valid;
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   // Address and data are latched separately and may come in either
   // order; one outstanding write keeps the response logic trivial.
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [1:0] w1c = (do_write && aw_addr_reg == `OFS_IRQ_STATUS &&
                     w_strb_reg[0]) ? w_data_reg[1:0] : 2'b00;

   always @(posedge aclk) begin
      if (!aresetn) begin
         prio_a_reg   <= `PRIO_A_RESET;
         prio_b_reg   <= `PRIO_B_RESET;
         adv_mode_reg <= `MODE_RESET;
         mask_reg     <= 2'b00;
         status_reg   <= 2'b00;
         aw_held_reg  <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_held_reg   <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         // Set wins over a same-cycle write-one clear
         status_reg <= (status_reg & ~w1c) | events;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case (aw_addr_reg)
               `OFS_PRIO_A: begin
                  if (w_strb_reg[0])
                     prio_a_reg <= w_data_reg[7:0] & `PA_WMASK;
               end
               `OFS_PRIO_B: begin
                  if (w_strb_reg[0])
                     prio_b_reg <= w_data_reg[7:0] & `PB_WMASK;
               end
               `OFS_MODE: begin
                  if (w_strb_reg[0])
                     adv_mode_reg <= w_data_reg[0];
               end
               `OFS_IRQ_MASK: begin
                  if (w_strb_reg[0])
                     mask_reg <= w_data_reg[1:0];
               end
               `OFS_IRQ_STATUS, `OFS_VECTOR: begin
               end
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            `OFS_PRIO_A:     s_axi_rdata <= {24'h000000, prio_a_reg};
            `OFS_PRIO_B:     s_axi_rdata <= {24'h000000, prio_b_reg};
            `OFS_MODE:       s_axi_rdata <= {31'h00000000, adv_mode_reg};
            `OFS_VECTOR:     s_axi_rdata <= {req_valid, 6'h00, req_level,
                                             2'h0, req_vector,
                                             req_address};
            `OFS_IRQ_STATUS: s_axi_rdata <= {30'h00000000, status_reg};
            `OFS_IRQ_MASK:   s_axi_rdata <= {30'h00000000, mask_reg};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

//--- verification/resolver_chk.sv
// Concurrent checks on the resolver ports
`timescale 1ns/1ps
module resolver_chk (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   // Sources
   input wire        nmi_request,
   input wire        ext_request_0,
   input wire        ext_request_1,
   input wire        ext_request_4,
   input wire        ext_request_5,
   input wire        watchdog_interval_overflow,
   input wire [2:0]  timer0_req,
   input wire [2:0]  timer1_req,
   input wire [2:0]  timer2_req,
   input wire [2:0]  timer3_req,
   input wire [2:0]  timer4_req,
   input wire [3:0]  serial0_req,
   input wire [3:0]  serial1_req,
   input wire        adc_conversion_end,
   // Resolved request
   input wire        req_valid,
   input wire [5:0]  req_vector,
   input wire [15:0] req_address,
   input wire        req_level
);
   wire other_src = nmi_request | ext_request_0 | ext_request_1
      | ext_request_4 | ext_request_5 | watchdog_interval_overflow
      | (|timer0_req) | (|timer1_req) | (|timer2_req) | (|timer3_req)
      | (|timer4_req) | (|serial0_req) | (|serial1_req);
   wire any_src = other_src | adc_conversion_end;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_nmi_top: assert property (nmi_request |=> req_vector == 6'h07
      && req_level && req_address inside {16'h000E, 16'h001C})
      else $error("non-maskable request did not win");
   chk_addr_scale: assert property (req_valid |->
      req_address == {9'h000, req_vector, 1'b0}
      || req_address == {8'h00, req_vector, 2'b00})
      else $error("table address not scaled from vector");
   chk_valid_follow: assert property (any_src |=> req_valid)
      else $error("pending request not presented");
   chk_idle_clear: assert property (!any_src |=> !req_valid
      && req_vector == 6'h00 && req_address == 16'h0000)
      else $error("request shown with nothing pending");
   chk_no_reserved: assert property (req_valid |-> req_vector >= 6'h07
      && req_vector <= 6'h3C && !(req_vector inside {[14:15], [18:19],
      [21:23], 27, 31, 35, 39, [43:51]}))
      else $error("reserved vector presented");
   chk_ext0_order: assert property (ext_request_0 && !nmi_request
      |=> req_level || req_vector == 6'h0C)
      else $error("level-0 winner beat external request 0");
   chk_adc_last: assert property (adc_conversion_end && !other_src
      |=> req_vector == 6'h3C)
      else $error("conversion end request not on its vector");
   chk_nmi_cause: assert property (req_vector == 6'h07
      |-> $past(nmi_request))
      else $error("vector seven without its request");
   chk_resp_hold: assert property (s_axi_bvalid |=> ($past(s_axi_bready)
      ? !s_axi_bvalid : (s_axi_bvalid && $stable(s_axi_bresp))))
      else $error("write response not held until taken");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read address taken without data next cycle");
endmodule

bind interrupt_vector_priority_resolver resolver_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_arready(s_axi_arready),
   .s_axi_arvalid(s_axi_arvalid),
   .nmi_request(nmi_request), .ext_request_0(ext_request_0),
   .ext_request_1(ext_request_1), .ext_request_4(ext_request_4),
   .ext_request_5(ext_request_5),
   .watchdog_interval_overflow(watchdog_interval_overflow),
   .timer0_req(timer0_req), .timer1_req(timer1_req),
   .timer2_req(timer2_req), .timer3_req(timer3_req),
   .timer4_req(timer4_req), .serial0_req(serial0_req),
   .serial1_req(serial1_req), .adc_conversion_end(adc_conversion_end),
   .req_valid(req_valid), .req_vector(req_vector),
   .req_address(req_address), .req_level(req_level));

//--- verification/exception_core_model.sv
// Core-side model that latches the presented vector each cycle
`timescale 1ns/1ps
module exception_core_model (
   input  wire  logic        aclk,
   input  wire  logic        req_valid,
   input  wire  logic [5:0]  req_vector,
   output logic [5:0]        seen_vector
);
   // Only a valid request is taken; an idle cycle shows vector zero
   always @(posedge aclk) begin
      seen_vector <= req_valid ? req_vector : 6'h00;
   end
endmodule

//--- verification/interrupt_vector_priority_resolver_tb_top.sv
// Self-checking bench for the interrupt vector priority resolver
`timescale 1ns/1ps
`include "vector_resolver_consts.vh"
module interrupt_vector_priority_resolver_tb_top;
   localparam logic [63:0] SRC = 64'h1FF0_0777_7713_3080;
   localparam logic [15:0] WM = {`PB_WMASK, `PA_WMASK};
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, pa = 8'h00, pb = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0] wstrb = 4'hF, s0 = 4'h0, s1 = 4'h0;
   logic nmi = 1'b0, e0 = 1'b0, e1 = 1'b0, e4 = 1'b0, e5 = 1'b0;
   logic wdt = 1'b0, adc = 1'b0;
   logic [2:0] t0 = 3'h0, t1 = 3'h0, t2 = 3'h0, t3 = 3'h0, t4 = 3'h0;
   logic [63:0] m;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, rq_valid, rq_lvl, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [5:0] rq_vec, seen_vec;
   wire [15:0] rq_addr;
   int fails = 0, check_count = 0;

   always #20 aclk = ~aclk;

   interrupt_vector_priority_resolver DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .nmi_request(nmi), .ext_request_0(e0),
      .ext_request_1(e1), .ext_request_4(e4), .ext_request_5(e5),
      .watchdog_interval_overflow(wdt), .timer0_req(t0), .timer1_req(t1),
      .timer2_req(t2), .timer3_req(t3), .timer4_req(t4),
      .serial0_req(s0), .serial1_req(s1), .adc_conversion_end(adc),
      .req_valid(rq_valid), .req_vector(rq_vec), .req_address(rq_addr),
      .req_level(rq_lvl), .irq(irq));
   exception_core_model core (.aclk(aclk), .req_valid(rq_valid),
      .req_vector(rq_vec), .seen_vector(seen_vec));

   // ==========================================
   // Compare, verdict and bus tasks
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Each channel is released at the edge that takes it, never earlier
   task bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tr, dn;
      n = 0;
      dn = 1'b0;
      @(posedge aclk);
      if (wr) begin
         awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      end
      while (!dn && n < 40) begin
         #1;
         ta = awvalid && awready;
         tw = wvalid && wready;
         tr = arvalid && arready;
         dn = wr ? bvalid && bready : rvalid && rready;
         rd = rdata;
         rs = wr ? bresp : rresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         if (dn) begin bready <= 1'b0; rready <= 1'b0; end
         n++;
      end
      if (!dn) fails++;
   endtask
   task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask

   // ==========================================
   // Source drive and expected winner
   task set_pend(input logic [63:0] p);
      @(posedge aclk);
      nmi <= p[7]; e0 <= p[12]; e1 <= p[13]; e4 <= p[16]; e5 <= p[17];
      wdt <= p[20]; t0 <= p[26:24]; t1 <= p[30:28]; t2 <= p[34:32];
      t3 <= p[38:36]; t4 <= p[42:40]; s0 <= p[55:52]; s1 <= p[59:56];
      adc <= p[60];
      repeat (2) @(posedge aclk);
      #1;
   endtask
   function automatic logic lvl(input int v);
      if (v == 12) return pa[7];
      if (v == 13) return pa[6];
      if (v inside {16, 17}) return pa[4];
      if (v == 20) return pa[3];
      if (v inside {[24:26]}) return pa[2];
      if (v inside {[28:30]}) return pa[1];
      if (v inside {[32:34]}) return pa[0];
      if (v inside {[36:38]}) return pb[7];
      if (v inside {[40:42]}) return pb[6];
      if (v inside {[52:55]}) return pb[3];
      if (v inside {[56:59]}) return pb[2];
      return v == 60 ? pb[1] : 1'b0;
   endfunction
   function automatic int exp_win(input logic [63:0] p);
      if (p[7]) return 7;
      for (int v = 0; v < 64; v++) if (p[v] && lvl(v)) return v;
      for (int v = 0; v < 64; v++) if (p[v]) return v;
      return 0;
   endfunction
   task check_res(input logic [63:0] p, input bit adv);
      int w;
      set_pend(p);
      w = exp_win(p);
      chk("vector", w, rq_vec);
      chk("address", adv ? w * 4 : w * 2, rq_addr);
      chk("valid", p != 0, rq_valid);
      chk("core vector", w, seen_vec);
   endtask

   // ==========================================
   // Test sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("prio a", `OFS_PRIO_A, 32'h0);
      rchk("prio b", `OFS_PRIO_B, 32'h0);
      rchk("mode", `OFS_MODE, 32'h0);
      rchk("mask", `OFS_IRQ_MASK, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped resp", 32'h2, rs);
      chk("unmapped data", 32'h0, rd);
      bus(1'b1, 8'h20, 32'h0);
      chk("unmapped wresp", 32'h2, rs);
      $display("test reset done");
      for (int md = 0; md < 2; md++) begin
         bus(1'b1, `OFS_MODE, md);
         for (int v = 0; v < 64; v++)
            if (SRC[v]) check_res(64'h1 << v, md);
      end
      $display("test vector map done");
      m = SRC;
      while (m != 0) begin
         check_res(m, 1'b1);
         m[exp_win(m)] = 1'b0;
      end
      $display("test default order done");
      for (int b = 0; b < 16; b++) if (WM[b]) begin
         {pb, pa} = 16'h1 << b;
         bus(1'b1, `OFS_PRIO_A, {24'h0, pa});
         bus(1'b1, `OFS_PRIO_B, {24'h0, pb});
         check_res(SRC & ~64'h80, 1'b1);
         check_res(SRC, 1'b1);
      end
      bus(1'b1, `OFS_PRIO_A, 32'hFF);
      rchk("prio a", `OFS_PRIO_A, 32'hDF);
      bus(1'b1, `OFS_PRIO_B, 32'hFF);
      rchk("prio b", `OFS_PRIO_B, 32'hCE);
      {pb, pa} = 16'hCEDF;
      check_res(SRC & ~64'h80, 1'b1);
      $display("test group priority done");
      set_pend(64'h0);
      bus(1'b1, `OFS_IRQ_STATUS, 32'h3);
      rchk("status", `OFS_IRQ_STATUS, 32'h0);
      set_pend(64'h1000);
      rchk("status", `OFS_IRQ_STATUS, 32'h2);
      chk("irq masked", 32'h0, irq);
      bus(1'b1, `OFS_IRQ_MASK, 32'h2);
      chk("irq", 32'h1, irq);
      bus(1'b1, `OFS_IRQ_STATUS, 32'h2);
      chk("irq cleared", 32'h0, irq);
      set_pend(64'h1080);
      rchk("status", `OFS_IRQ_STATUS, 32'h3);
      rchk("view", `OFS_VECTOR, 32'h8107001C);
      chk("irq", 32'h1, irq);
      $display("test interrupt done");
      results;
   end

   // Whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      results;
   end
endmodule
